// ### micp_pkg.sv
package micp_pkg;
  // register offsets
  localparam logic [7:0] ADDR_RLS   = 8'h40;
  localparam logic [7:0] ADDR_STS1  = 8'h41;
  localparam logic [7:0] ADDR_STS2  = 8'h42;
  localparam logic [7:0] ADDR_SFR   = 8'h7c;
  localparam logic [7:0] ADDR_VEN   = 8'h7e;
  localparam logic [7:0] ADDR_CFG   = 8'h7f;
  localparam logic [7:0] ADDR_FEN   = 8'h80;
  localparam logic [7:0] ADDR_TEN   = 8'h82;
  localparam logic [7:0] ADDR_RD1   = 8'h25;
  localparam logic [7:0] ADDR_RD2   = 8'h27;
  // reset values
  localparam logic [7:0] RST_ZERO   = 8'h00;
  localparam logic [7:0] RST_SFR    = 8'h40;
  // special codes
  localparam logic [7:0] SENSOR_ERR = 8'h80;
  localparam logic [7:0] DIS_READ   = 8'h00;
  // ready/lock/start fields
  localparam int RLS_START = 0;
  localparam int RLS_LOCK  = 1;
  localparam int RLS_READY = 2;
  // special function fields
  localparam int SFR_LPSEL = 0;
  localparam int SFR_GIE   = 2;
  localparam logic [7:0] SFR_LP_MASK = 8'h07;
  // configuration fields
  localparam int CFG_IRQ_ON_TACH_THREE_PIN = 0;
  localparam int CFG_IRQ_ON_PWM_TWO_PIN = 1;
  localparam int CFG_INIT  = 7;
  // enable register fields (bit 0 is the group enable)
  localparam int EN_GROUP = 0;
  localparam int TEN_D1   = 1;
  localparam int TEN_D2   = 2;
  localparam int TEN_AMB  = 3;
  localparam int VEN_VCC  = 1;
  localparam int VEN_VCCP = 2;
  localparam int FEN_TACH = 1;
  // status one fields
  localparam int S1_VCC  = 0;
  localparam int S1_VCCP = 1;
  localparam int S1_D1   = 2;
  localparam int S1_AMB  = 3;
  localparam int S1_D2   = 4;
  // status two fields
  localparam int S2_TACH = 0;
  localparam int S2_F1   = 6;
  localparam int S2_F2   = 7;
  localparam int NTACH   = 4;

  typedef struct packed {
    logic             d1_lim;
    logic             amb_lim;
    logic             d2_lim;
    logic             vcc_lim;
    logic             vccp_lim;
    logic [NTACH-1:0] tach_lim;
  } micp_cond_t;

  typedef struct packed {
    logic open_ckt;
    logic p_vcc;
    logic p_gnd;
    logic n_vcc;
    logic n_gnd;
  } micp_fault_t;
endpackage

// ### micp_top.sv
// Overview of operation
// - a detected violation or diode fault sets its status bit
// - a status read clears only bits whose cause has ended
// - status registers ignore writes and zero on reset and soft init
// - a cleared individual enable stops its event setting the status bit
// - open diode or any terminal short sets that diode's fault bit
// - a diode fault loads the error code, except negative terminal to ground
// - a reading equal to the error code sets the diode temperature error
// - fault bits never drive the interrupt output directly
// - zone fans run fully on while the diode reading holds error code
// - disabled diode: no fault bit, fault loads zero, else normal reading
// - interrupt routed to fan-two or speed-three pin, gated by global enable
// - group enables admit temperature, voltage and fan events
// - temperature events assert interrupt under all three enables
// - voltage events assert interrupt under all three enables
// - tach events assert interrupt under all three enables
// - with global enable, interrupt stays low while a group-enabled status bit stays set, until released
// - an alert response read releases the interrupt output
// - interrupt goes active only while monitoring runs
// - start cleared enters sleep or shutdown; pwm at full duty
// - lock bit freezes start and low-power select
// - sleep keeps all access; shutdown allows few bits, write only
// - configuration bit seven soft-resets all but reading registers
module micp_top
  import micp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata,
  input  wire logic        ara_read,
  input  wire logic        conv_done,
  input  wire micp_cond_t  cond,
  input  wire micp_fault_t fault_one,
  input  wire micp_fault_t fault_two,
  input  wire logic [7:0]  raw_one,
  input  wire logic [7:0]  raw_two,
  input  wire logic        pwm_two_in,
  output logic [7:0]       reading_one,
  output logic [7:0]       reading_two,
  output logic [1:0]       zone_full_on,
  output logic             pwm_full_duty,
  output logic             monitor_running,
  output logic             sleep_mode,
  output logic             shutdown_mode,
  output logic             irq_n,
  output logic             fan_drive_two_pin,
  output logic             speed_input_three_pin_out,
  output logic             speed_input_three_pin_oe
);

  logic [7:0] rls_q, rls_d;
  logic [7:0] sts1_q, sts1_d;
  logic [7:0] sts2_q, sts2_d;
  logic [7:0] sfr_q, sfr_d;
  logic [7:0] ven_q, ven_d;
  logic [7:0] cfg_q, cfg_d;
  logic [7:0] fen_q, fen_d;
  logic [7:0] ten_q, ten_d;
  logic [7:0] rd1_q, rd1_d;
  logic [7:0] rd2_q, rd2_d;
  logic [7:0] rdata_q, rdata_d;
  logic       released_q, released_d;

  // mode decode
  wire start      = rls_q[RLS_START];
  wire locked     = rls_q[RLS_LOCK];
  wire lp_shut    = ~start & sfr_q[SFR_LPSEL];
  wire lp_sleep   = ~start & ~sfr_q[SFR_LPSEL];
  wire soft_init  = reg_wr & (reg_addr == ADDR_CFG)
                  & reg_wdata[CFG_INIT];
  // conversions only count while monitoring
  wire conv       = conv_done & start;

  // address decode
  wire hit_rls  = reg_addr == ADDR_RLS;
  wire hit_sts1 = reg_addr == ADDR_STS1;
  wire hit_sts2 = reg_addr == ADDR_STS2;
  wire hit_sfr  = reg_addr == ADDR_SFR;
  wire hit_ven  = reg_addr == ADDR_VEN;
  wire hit_cfg  = reg_addr == ADDR_CFG;
  wire hit_fen  = reg_addr == ADDR_FEN;
  wire hit_ten  = reg_addr == ADDR_TEN;
  wire hit_rd1  = reg_addr == ADDR_RD1;
  wire hit_rd2  = reg_addr == ADDR_RD2;
  // shutdown leaves only sfr and config, and only for writes
  wire wr_ok    = reg_wr & (~lp_shut | hit_sfr | hit_cfg);
  wire rd_ok    = reg_rd & ~lp_shut;
  wire rd_sts1  = rd_ok & hit_sts1;
  wire rd_sts2  = rd_ok & hit_sts2;

  // diode fault detection
  wire flt1_any = |fault_one;
  wire flt2_any = |fault_two;
  wire flt1_ld  = flt1_any & ~(fault_one.n_gnd
                  & ~(fault_one.open_ckt | fault_one.p_vcc
                  | fault_one.p_gnd | fault_one.n_vcc));
  wire flt2_ld  = flt2_any & ~(fault_two.n_gnd
                  & ~(fault_two.open_ckt | fault_two.p_vcc
                  | fault_two.p_gnd | fault_two.n_vcc));
  wire remote_one_enable    = ten_q[TEN_D1];
  wire remote_two_enable    = ten_q[TEN_D2];

  // reading selection
  wire [7:0] new_rd1 = ~flt1_ld ? raw_one
                     : remote_one_enable    ? SENSOR_ERR
                     :            DIS_READ;
  wire [7:0] new_rd2 = ~flt2_ld ? raw_two
                     : remote_two_enable    ? SENSOR_ERR
                     :            DIS_READ;

  // causes, both as sampled now and as latched in the readings
  wire d1_err_now = cond.d1_lim | (new_rd1 == SENSOR_ERR);
  wire d2_err_now = cond.d2_lim | (new_rd2 == SENSOR_ERR);
  wire d1_err_hold = cond.d1_lim | (rd1_q == SENSOR_ERR);
  wire d2_err_hold = cond.d2_lim | (rd2_q == SENSOR_ERR);

  // live causes, one per status bit
  logic [7:0] cause1, cause2, en1, en2, cset1, cset2;
  always_comb
  begin
    cause1 = RST_ZERO;
    cause1[S1_VCC]  = cond.vcc_lim;
    cause1[S1_VCCP] = cond.vccp_lim;
    cause1[S1_D1]   = d1_err_hold;
    cause1[S1_AMB]  = cond.amb_lim;
    cause1[S1_D2]   = d2_err_hold;
    cause2 = RST_ZERO;
    cause2[S2_TACH +: NTACH] = cond.tach_lim;
    cause2[S2_F1]   = flt1_any;
    cause2[S2_F2]   = flt2_any;
    // per-bit enables
    en1 = RST_ZERO;
    en1[S1_VCC]  = ven_q[VEN_VCC];
    en1[S1_VCCP] = ven_q[VEN_VCCP];
    en1[S1_D1]   = remote_one_enable;
    en1[S1_AMB]  = ten_q[TEN_AMB];
    en1[S1_D2]   = remote_two_enable;
    en2 = RST_ZERO;
    en2[S2_TACH +: NTACH] = fen_q[FEN_TACH +: NTACH];
    en2[S2_F1]   = remote_one_enable;
    en2[S2_F2]   = remote_two_enable;
    // causes seen at this conversion
    cset1 = cause1;
    cset1[S1_D1] = d1_err_now;
    cset1[S1_D2] = d2_err_now;
    cset2 = cause2;
  end

  wire [7:0] set1 = {8{conv}} & cset1 & en1;
  wire [7:0] set2 = {8{conv}} & cset2 & en2;
  wire [7:0] clr1 = {8{rd_sts1}} & ~cause1;
  wire [7:0] clr2 = {8{rd_sts2}} & ~cause2;

  // interrupt gating; fault bits are left out on purpose
  wire grp_temp = ten_q[EN_GROUP] & |(sts1_q & ((8'h01 << S1_D1)
                  | (8'h01 << S1_AMB) | (8'h01 << S1_D2)));
  wire grp_volt = ven_q[EN_GROUP] & |(sts1_q & ((8'h01 << S1_VCC)
                  | (8'h01 << S1_VCCP)));
  wire grp_fan  = fen_q[EN_GROUP]
                  & |sts2_q[S2_TACH +: NTACH];
  wire pending  = (grp_temp | grp_volt | grp_fan)
                  & sfr_q[SFR_GIE] & start;
  wire irq_act  = pending & ~released_q;
  wire new_set  = |(set1 & ~sts1_q) | |(set2 & ~sts2_q);
  // taken from the write itself, so the line reasserts with the enable
  wire gie_rise = sfr_d[SFR_GIE] & ~sfr_q[SFR_GIE];

  // register next values
  always_comb
  begin
    rls_d  = rls_q;
    sfr_d  = sfr_q;
    ven_d  = ven_q;
    cfg_d  = cfg_q;
    fen_d  = fen_q;
    ten_d  = ten_q;
    // writes never reach status bits
    sts1_d = (sts1_q & ~clr1) | set1;
    sts2_d = (sts2_q & ~clr2) | set2;
    if (wr_ok & hit_rls)
    begin
      rls_d[RLS_LOCK] = rls_q[RLS_LOCK] | reg_wdata[RLS_LOCK];
      if (!locked)
        rls_d[RLS_START] = reg_wdata[RLS_START];
    end
    if (wr_ok & hit_sfr)
    begin
      if (lp_shut)
        sfr_d = (sfr_q & ~SFR_LP_MASK)
              | (reg_wdata & SFR_LP_MASK);
      else
        sfr_d = reg_wdata;
      if (locked)
        sfr_d[SFR_LPSEL] = sfr_q[SFR_LPSEL];
    end
    if (wr_ok & hit_ven)
      ven_d = reg_wdata;
    if (wr_ok & hit_cfg)
    begin
      cfg_d = reg_wdata;
      cfg_d[CFG_INIT] = 1'b0;
    end
    if (wr_ok & hit_fen)
      fen_d = reg_wdata;
    if (wr_ok & hit_ten)
      ten_d = reg_wdata;
    // soft init, readings excluded
    if (soft_init)
    begin
      rls_d  = RST_ZERO;
      sfr_d  = RST_SFR;
      ven_d  = RST_ZERO;
      cfg_d  = RST_ZERO;
      fen_d  = RST_ZERO;
      ten_d  = RST_ZERO;
      sts1_d = RST_ZERO;
      sts2_d = RST_ZERO;
    end
  end

  // readings update once per conversion and survive soft init
  assign rd1_d = conv ? new_rd1 : rd1_q;
  assign rd2_d = conv ? new_rd2 : rd2_q;

  // alert response drops the line until something new arrives
  assign released_d = soft_init ? 1'b0
                    : ara_read  ? 1'b1
                    : (new_set | gie_rise) ? 1'b0
                    : released_q;

  // read mux; shutdown keeps the last read data since registers are write only
  logic [7:0] rmux;
  always_comb
  begin
    rmux = RST_ZERO;
    if (hit_rls)
    begin
      rmux = rls_q;
      rmux[RLS_READY] = 1'b1;
    end
    else if (hit_sts1)
      rmux = sts1_q;
    else if (hit_sts2)
      rmux = sts2_q;
    else if (hit_sfr)
      rmux = sfr_q;
    else if (hit_ven)
      rmux = ven_q;
    else if (hit_cfg)
      rmux = cfg_q;
    else if (hit_fen)
      rmux = fen_q;
    else if (hit_ten)
      rmux = ten_q;
    else if (hit_rd1)
      rmux = rd1_q;
    else if (hit_rd2)
      rmux = rd2_q;
  end
  assign rdata_d = rd_ok ? rmux : rdata_q;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rls_q  <= RST_ZERO;
      sts1_q <= RST_ZERO;
      sts2_q <= RST_ZERO;
      sfr_q  <= RST_SFR;
      ven_q  <= RST_ZERO;
      cfg_q  <= RST_ZERO;
      fen_q  <= RST_ZERO;
      ten_q  <= RST_ZERO;
    end
    else
    begin
      rls_q  <= rls_d;
      sts1_q <= sts1_d;
      sts2_q <= sts2_d;
      sfr_q  <= sfr_d;
      ven_q  <= ven_d;
      cfg_q  <= cfg_d;
      fen_q  <= fen_d;
      ten_q  <= ten_d;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rd1_q      <= RST_ZERO;
      rd2_q      <= RST_ZERO;
      rdata_q    <= RST_ZERO;
      released_q <= 1'b0;
    end
    else
    begin
      rd1_q      <= rd1_d;
      rd2_q      <= rd2_d;
      rdata_q    <= rdata_d;
      released_q <= released_d;
    end
  end

  // outputs
  assign reg_rdata       = rdata_q;
  assign reading_one     = rd1_q;
  assign reading_two     = rd2_q;
  assign zone_full_on[0] = rd1_q == SENSOR_ERR;
  assign zone_full_on[1] = rd2_q == SENSOR_ERR;
  assign pwm_full_duty   = ~start;
  assign monitor_running = start;
  assign sleep_mode      = lp_sleep;
  assign shutdown_mode   = lp_shut;
  assign irq_n           = ~irq_act;
  // pin sharing: pwm path when not routed
  assign fan_drive_two_pin = cfg_q[CFG_IRQ_ON_PWM_TWO_PIN] ? ~irq_act
                           : pwm_two_in;
  assign speed_input_three_pin_out = 1'b0;
  assign speed_input_three_pin_oe  = cfg_q[CFG_IRQ_ON_TACH_THREE_PIN]
                                   & irq_act;

endmodule // micp_top

// ### micp_host.sv
module micp_host
  import micp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic            ara_read
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ara_read = 1'b0;
  end
  // released lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
  task automatic ara();
    @(negedge clk);
    ara_read = 1'b1;
    @(negedge clk);
    ara_read = 1'b0;
  endtask
  // gate off before reading so live events assert again
  task automatic rearm(input logic [7:0] a, output logic [7:0] d);
    wr(ADDR_SFR, RST_SFR);
    rd(a, d);
    wr(ADDR_SFR, RST_SFR | 8'h04);
  endtask
endmodule // micp_host

// ### micp_props.sv
module micp_props
  import micp_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_rdata,
  input wire logic        ara_read,
  input wire logic        conv_done,
  input wire micp_fault_t fault_one,
  input wire logic [7:0]  raw_one,
  input wire logic [7:0]  reading_one,
  input wire logic [1:0]  zone_full_on,
  input wire logic        pwm_full_duty,
  input wire logic        monitor_running,
  input wire logic        sleep_mode,
  input wire logic        shutdown_mode,
  input wire logic        irq_n,
  input wire logic        pwm_two_in,
  input wire logic        fan_drive_two_pin,
  input wire logic        speed_input_three_pin_out,
  input wire logic        speed_input_three_pin_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  sequence s_conv;
    conv_done && monitor_running;
  endsequence
  sequence s_open;
    s_conv ##0 fault_one.open_ckt;
  endsequence
  sequence s_clean;
    s_conv ##0 (fault_one == '0);
  endsequence
  property p_fault_load;
    s_open |=> reading_one inside {SENSOR_ERR, DIS_READ};
  endproperty
  a_fault_load: assert property (p_fault_load)
    else $error("open diode loaded a normal reading");
  property p_clean_load;
    s_clean |=> reading_one == $past(raw_one);
  endproperty
  a_clean_load: assert property (p_clean_load)
    else $error("fault free reading not stored");
  property p_zone;
    zone_full_on[0] == (reading_one == SENSOR_ERR);
  endproperty
  a_zone: assert property (p_zone)
    else $error("zone full on mismatch");
  property p_idle_quiet;
    !monitor_running |-> irq_n;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("interrupt active while stopped");
  property p_full_duty;
    pwm_full_duty == !monitor_running;
  endproperty
  a_full_duty: assert property (p_full_duty)
    else $error("full duty flag wrong");
  property p_modes;
    monitor_running ? !(sleep_mode || shutdown_mode)
                    : (sleep_mode ^ shutdown_mode);
  endproperty
  a_modes: assert property (p_modes)
    else $error("low power mode decode wrong");
  property p_ara;
    ara_read && !conv_done && !reg_wr |=> irq_n;
  endproperty
  a_ara: assert property (p_ara)
    else $error("alert response did not release");
  property p_irq_cause;
    $fell(irq_n) |-> $past(conv_done) || $past(reg_wr);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt fell without a cause");
  property p_shut_read;
    reg_rd && shutdown_mode |=> $stable(reg_rdata);
  endproperty
  a_shut_read: assert property (p_shut_read)
    else $error("read answered in shutdown");
  property p_fan_pin;
    fan_drive_two_pin != pwm_two_in |-> fan_drive_two_pin == irq_n;
  endproperty
  a_fan_pin: assert property (p_fan_pin)
    else $error("fan pin carries neither source");
  property p_t3_pin;
    speed_input_three_pin_oe |-> !irq_n && !speed_input_three_pin_out;
  endproperty
  a_t3_pin: assert property (p_t3_pin)
    else $error("speed pin driven without interrupt");
endmodule // micp_props
bind micp_top micp_props u_props (.clk(clk), .reset_n(reset_n),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .ara_read(ara_read), .conv_done(conv_done), .fault_one(fault_one),
  .raw_one(raw_one), .reading_one(reading_one),
  .zone_full_on(zone_full_on), .pwm_full_duty(pwm_full_duty),
  .monitor_running(monitor_running), .sleep_mode(sleep_mode),
  .shutdown_mode(shutdown_mode), .irq_n(irq_n), .pwm_two_in(pwm_two_in),
  .fan_drive_two_pin(fan_drive_two_pin),
  .speed_input_three_pin_out(speed_input_three_pin_out),
  .speed_input_three_pin_oe(speed_input_three_pin_oe));

// ### testbench.sv
module testbench import micp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, raw_one, raw_two, rd_d;
  logic [7:0]  reading_one, reading_two;
  logic        reg_wr, reg_rd, ara_read, conv_done, pwm_two_in;
  logic [1:0]  zone_full_on;
  logic        pwm_full_duty, monitor_running, sleep_mode, shutdown_mode;
  logic        irq_n, fan_drive_two_pin, t3_out, t3_oe;
  micp_cond_t  cond;
  micp_fault_t fault_one, fault_two;
  int          n_mismatch = 0;
  int          total_checks = 0;
  always #4 clk = ~clk;
  micp_top uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ara_read(ara_read), .conv_done(conv_done),
    .cond(cond), .fault_one(fault_one), .fault_two(fault_two),
    .raw_one(raw_one), .raw_two(raw_two), .pwm_two_in(pwm_two_in),
    .reading_one(reading_one), .reading_two(reading_two),
    .zone_full_on(zone_full_on), .pwm_full_duty(pwm_full_duty),
    .monitor_running(monitor_running), .sleep_mode(sleep_mode),
    .shutdown_mode(shutdown_mode), .irq_n(irq_n),
    .fan_drive_two_pin(fan_drive_two_pin),
    .speed_input_three_pin_out(t3_out), .speed_input_three_pin_oe(t3_oe));
  micp_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .ara_read(ara_read));
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, e);
  endtask
  task automatic conv(input micp_cond_t c, input micp_fault_t f,
                      input logic [7:0] r);
    @(negedge clk);
    cond = c;
    fault_one = f;
    raw_one = r;
    conv_done = 1'b1;
    @(negedge clk);
    conv_done = 1'b0;
  endtask
  task automatic t_reset();
    rchk(ADDR_STS1, RST_ZERO);
    rchk(ADDR_STS2, RST_ZERO);
    rchk(8'h99, 8'h00);
    chk(8'(pwm_full_duty), 8'h01);
    chk(8'(fan_drive_two_pin), 8'(pwm_two_in));
    chk(8'(t3_oe), 8'h00);
  endtask
  task automatic t_fault();
    host.wr(ADDR_RLS, 8'h01);
    host.wr(ADDR_TEN, 8'h03);
    host.wr(ADDR_SFR, 8'h44);
    for (int i = 1; i < 5; i++)
    begin
      conv('0, 5'(1 << i), 8'h19);
      chk(reading_one, SENSOR_ERR);
    end
    chk(8'(zone_full_on), 8'h01);
    chk(8'(irq_n), 8'h00);
    rchk(ADDR_STS1, 8'h04);
    rchk(ADDR_STS1, 8'h04);
    conv('0, '0, 8'h19);
    rchk(ADDR_STS2, 8'h40);
    rchk(ADDR_STS2, 8'h00);
    rchk(ADDR_STS1, 8'h04);
    rchk(ADDR_STS1, 8'h00);
    chk(8'(irq_n), 8'h01);
    conv('0, 5'b00001, 8'h19);
    chk(reading_one, 8'h19);
    chk(8'(irq_n), 8'h01);
    rchk(ADDR_STS2, 8'h40);
  endtask
  task automatic t_disabled();
    host.wr(ADDR_TEN, 8'h01);
    conv(9'h100, 5'b10000, 8'h19);
    chk(reading_one, DIS_READ);
    rchk(ADDR_STS2, 8'h40);
    conv('0, '0, 8'h2b);
    chk(reading_one, 8'h2b);
    rchk(ADDR_STS2, 8'h40);
    conv(9'h100, 5'b10000, 8'h2b);
    rchk(ADDR_STS2, 8'h00);
    rchk(ADDR_STS1, 8'h00);
  endtask
  task automatic t_remote_two();
    host.wr(ADDR_TEN, 8'h05);
    fault_two = 5'b01000;
    conv('0, '0, 8'h19);
    chk(reading_two, SENSOR_ERR);
    chk(8'(zone_full_on), 8'h02);
    chk(8'(irq_n), 8'h00);
    fault_two = '0;
    conv('0, '0, 8'h19);
    chk(reading_two, 8'h2a);
    chk(8'(zone_full_on), 8'h00);
    rchk(ADDR_STS2, 8'h80);
    rchk(ADDR_STS2, 8'h00);
    // clearing read and a fresh error land on one edge
    fault_two = 5'b01000;
    fork
      host.rd(ADDR_STS1, rd_d);
      conv('0, '0, 8'h19);
    join
    chk(rd_d, 8'h10);
    rchk(ADDR_STS1, 8'h10);
    fault_two = '0;
    conv('0, '0, 8'h19);
    rchk(ADDR_STS1, 8'h10);
    rchk(ADDR_STS1, 8'h00);
    chk(8'(irq_n), 8'h01);
    rchk(ADDR_STS2, 8'h80);
  endtask
  task automatic t_volt();
    host.wr(ADDR_VEN, 8'h03);
    conv(9'h020, '0, 8'h19);
    chk(8'(irq_n), 8'h00);
    host.wr(ADDR_STS1, 8'hff);
    rchk(ADDR_STS1, 8'h01);
    host.ara();
    chk(8'(irq_n), 8'h01);
    host.rearm(ADDR_STS1, rd_d);
    chk(rd_d, 8'h01);
    chk(8'(irq_n), 8'h00);
    host.wr(ADDR_CFG, 8'h03);
    chk(8'(fan_drive_two_pin), 8'h00);
    chk(8'(t3_oe), 8'h01);
    chk(8'(t3_out), 8'h00);
    host.wr(ADDR_VEN, 8'h02);
    chk(8'(irq_n), 8'h01);
    host.wr(ADDR_FEN, 8'h03);
    conv(9'h001, '0, 8'h19);
    chk(8'(irq_n), 8'h00);
    rchk(ADDR_STS2, 8'h01);
  endtask
  task automatic t_lowpower();
    host.wr(ADDR_RLS, 8'h00);
    chk(8'(irq_n), 8'h01);
    chk(8'({sleep_mode, shutdown_mode, pwm_full_duty}), 8'h05);
    rchk(ADDR_SFR, 8'h44);
    host.wr(ADDR_RLS, 8'h02);
    host.wr(ADDR_RLS, 8'h03);
    host.wr(ADDR_SFR, 8'h45);
    chk(8'({monitor_running, sleep_mode}), 8'h01);
    host.wr(ADDR_CFG, 8'h80);
    rchk(ADDR_STS2, RST_ZERO);
    rchk(ADDR_RLS, 8'h04);
    chk(reading_one, 8'h19);
    host.wr(ADDR_SFR, 8'h41);
    chk(8'(shutdown_mode), 8'h01);
    rchk(ADDR_SFR, 8'h04);
    host.wr(ADDR_RLS, 8'h01);
    chk(8'(monitor_running), 8'h00);
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
  initial
  begin
    conv_done = 1'b0;
    cond = '0;
    fault_one = '0;
    fault_two = '0;
    raw_one = 8'h00;
    raw_two = 8'h2a;
    pwm_two_in = 1'b1;
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_fault();
    t_disabled();
    t_remote_two();
    t_volt();
    t_lowpower();
    conclude();
  end
endmodule // testbench
